// >>> src/asss_pkg.sv
// Purpose: Constants and types for the automatic sound select block
// Assumes: 125 MHz device clock, 16-bit register data, 8-bit byte addresses
// Notes: Standard codes are the one-byte values written by the host
//
// What this block does
// - Deemphasis follows the active sound standard
// - Dematrix from manual select or automatic choice
// - Automatic dematrix follows identification, no host access
// - Alternate B/G FM and B/G NICAM silently
// - Alternate D/K FM variants and D/K NICAM
// - Alternate only without identification, then hold
// - NICAM fallback to analog mono with hysteresis
// - Four source channels at codes 0,1,3,4
// - Channel 0 analog; NICAM gives analog mono
// - Channel 1 bilingual: A left, B right
// - Channel 3 bilingual: language A both sides
// - Channel 4 bilingual: language B both sides
// - Dual-FM identification picks mono, stereo, bilingual
// - NICAM control bits pick mono, stereo, bilingual
// - Pilot picks mono or stereo; SECONDARY_AUDIO_PROGRAM detected
// - SECONDARY_AUDIO_PROGRAM standard: SECONDARY_AUDIO_PROGRAM if present, else stereo with pilot, else mono
// - NICAM bad: all channels analog mono
// - NICAM modes fill channels 1,3,4; 0 analog
// - Primary is mono/sum; secondary second/difference/SECONDARY_AUDIO_PROGRAM
// - One standard code sets demodulator parameters
package asss_pkg;
    localparam int CLK_KHZ = 125000;
    localparam int DWELL_MS = 500;
    localparam int DWELL_CYCLES = DWELL_MS * CLK_KHZ;
    localparam logic [7:0] NIC_ERR_HI = 8'hC0;
    localparam logic [7:0] NIC_ERR_LO = 8'h40;

    localparam logic [7:0] A_STD = 8'h00;
    localparam logic [7:0] A_CTRL = 8'h04;
    localparam logic [7:0] A_PRE_ANA = 8'h08;
    localparam logic [7:0] A_PRE_DIG = 8'h0C;
    localparam logic [7:0] A_STATUS = 8'h10;
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_MAT_LSB = 4;
    localparam logic [7:0] STD_RST = 8'h00;
    localparam logic [15:0] CTRL_RST = 16'h0001;
    localparam logic [15:0] PRE_RST = 16'h0000;

    localparam logic [7:0] S_M_KOREA = 8'h02;
    localparam logic [7:0] S_BG_FM = 8'h03;
    localparam logic [7:0] S_DK1_FM = 8'h04;
    localparam logic [7:0] S_DK2_FM = 8'h05;
    localparam logic [7:0] S_DK3_FM = 8'h07;
    localparam logic [7:0] S_BG_NIC = 8'h08;
    localparam logic [7:0] S_L_NIC = 8'h09;
    localparam logic [7:0] S_I_NIC = 8'h0A;
    localparam logic [7:0] S_DK_NIC = 8'h0B;
    localparam logic [7:0] S_DK_NIC_HD1 = 8'h0C;
    localparam logic [7:0] S_DK_NIC_HD2 = 8'h0D;
    localparam logic [7:0] S_BTSC = 8'h20;
    localparam logic [7:0] S_BTSC_SAP = 8'h21;
    localparam logic [7:0] S_M_JAPAN = 8'h30;
    localparam logic [7:0] S_FM_RADIO = 8'h40;

    localparam logic [1:0] DE_50US = 2'h0;
    localparam logic [1:0] DE_75US = 2'h1;
    localparam logic [1:0] DE_OFF = 2'h2;
    localparam logic [1:0] DE_J17 = 2'h3;
    localparam logic [1:0] DCB_STEREO = 2'h0;
    localparam logic [1:0] DCB_BILING = 2'h1;
    localparam logic [1:0] DCB_MONO = 2'h2;

    typedef enum logic [2:0] {
        MD_MONO = 3'h0,
        MD_STEREO = 3'h1,
        MD_BILING = 3'h2,
        MD_NIC_MONO = 3'h3,
        MD_NIC_STEREO = 3'h4,
        MD_NIC_BILING = 3'h5
    } asss_mode_e;

    typedef enum logic [2:0] {
        CL_OTHER = 3'h0,
        CL_FMID = 3'h1,
        CL_NICAM = 3'h2,
        CL_PILOT = 3'h3,
        CL_SAP = 3'h4
    } asss_class_e;
endpackage : asss_pkg

// >>> src/asss_top.sv
// Purpose: Demodulator post-processing and automatic sound select
// Assumes: Inputs synchronous to clk_i; sample_strobe_i marks audio samples
// Notes: Source channels 0, 1, 3 and 4 are the ch0..ch4 output pairs
//
// The address-and-strobe port and the register offsets were left to the implementer.
module asss_top
    import asss_pkg::*;
#(
    parameter int DWELL = DWELL_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [15:0] reg_rdata_o,
    // Identification from the demodulators
    input wire logic fm_id_stereo_i,
    input wire logic fm_id_bilingual_i,
    input wire logic [1:0] digital_sound_control_bits_i,
    input wire logic nicam_locked_i,
    input wire logic [7:0] nicam_err_rate_i,
    input wire logic pilot_i,
    input wire logic secondary_audio_program_i,
    // Demodulated audio
    input wire logic sample_strobe_i,
    input wire logic signed [15:0] primary_i,
    input wire logic signed [15:0] secondary_i,
    input wire logic signed [15:0] nicam_left_i,
    input wire logic signed [15:0] nicam_right_i,
    // Demodulator settings
    output logic [7:0] demod_std_o,
    output logic [1:0] deemph_analog_o,
    output logic [1:0] deemph_digital_o,
    output logic [15:0] prescale_analog_o,
    output logic [15:0] prescale_digital_o,
    output logic [2:0] dematrix_mode_o,
    // Source channels
    output logic sample_valid_o,
    output logic signed [15:0] ch0_left_o,
    output logic signed [15:0] ch0_right_o,
    output logic signed [15:0] ch1_left_o,
    output logic signed [15:0] ch1_right_o,
    output logic signed [15:0] ch3_left_o,
    output logic signed [15:0] ch3_right_o,
    output logic signed [15:0] ch4_left_o,
    output logic signed [15:0] ch4_right_o
);
    localparam logic [31:0] DWELL_LAST = 32'(DWELL - 1);

    function automatic asss_class_e std_class(input logic [7:0] s);
        case (s)
            S_M_KOREA, S_BG_FM, S_DK1_FM, S_DK2_FM, S_DK3_FM, S_M_JAPAN: return CL_FMID;
            S_BG_NIC, S_L_NIC, S_I_NIC, S_DK_NIC, S_DK_NIC_HD1, S_DK_NIC_HD2: return CL_NICAM;
            S_BTSC, S_FM_RADIO: return CL_PILOT;
            S_BTSC_SAP: return CL_SAP;
            default: return CL_OTHER;
        endcase
    endfunction : std_class

    function automatic logic [1:0] deemph_ana(input logic [7:0] s);
        case (s)
            S_M_KOREA, S_M_JAPAN, S_BTSC, S_BTSC_SAP, S_FM_RADIO: return DE_75US;
            S_L_NIC: return DE_OFF;
            default: return DE_50US;
        endcase
    endfunction : deemph_ana

    function automatic logic [1:0] deemph_dig(input logic [7:0] s);
        return (std_class(s) == CL_NICAM) ? DE_J17 : DE_OFF;
    endfunction : deemph_dig

    // Next standard sharing the same FM mono carrier; itself if none
    function automatic logic [7:0] next_alt(input logic [7:0] s);
        case (s)
            S_BG_FM: return S_BG_NIC;
            S_BG_NIC: return S_BG_FM;
            S_DK1_FM: return S_DK2_FM;
            S_DK2_FM: return S_DK3_FM;
            S_DK3_FM: return S_DK_NIC;
            S_DK_NIC: return S_DK1_FM;
            default: return s;
        endcase
    endfunction : next_alt

    function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
        if (v > 17'sh07FFF) begin
            return 16'sh7FFF;
        end
        if (v < 17'sh18000) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : sat16

    // Control state
    logic [7:0] std_sel_q, std_sel_d;
    logic [7:0] active_q, active_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] pre_ana_q, pre_ana_d;
    logic [15:0] pre_dig_q, pre_dig_d;
    logic [31:0] dwell_q, dwell_d;
    logic fallback_q, fallback_d;
    logic [15:0] rdata_q, rdata_d;
    logic [1:0] de_ana_q, de_ana_d;
    logic [1:0] de_dig_q, de_dig_d;
    asss_class_e cls;
    logic auto_en;
    logic id_found;
    logic std_wr;
    asss_mode_e mode_q, mode_d;

    assign cls = std_class(active_q);
    assign auto_en = ctrl_q[CTRL_AUTO_BIT];
    assign std_wr = reg_write_i && (reg_addr_i == A_STD);
    assign id_found = (cls == CL_FMID) ? (fm_id_stereo_i || fm_id_bilingual_i) :
                      (cls == CL_NICAM) ? nicam_locked_i : 1'b0;

    always_comb begin
        std_sel_d = std_sel_q;
        active_d = active_q;
        ctrl_d = ctrl_q;
        pre_ana_d = pre_ana_q;
        pre_dig_d = pre_dig_q;
        dwell_d = dwell_q;
        fallback_d = fallback_q;
        rdata_d = 16'h0000;
        de_ana_d = deemph_ana(active_q);
        de_dig_d = deemph_dig(active_q);
        if (auto_en && (next_alt(active_q) != active_q) && !id_found) begin
            if (dwell_q >= DWELL_LAST) begin
                active_d = next_alt(active_q);
                dwell_d = 32'h0000_0000;
            end else begin
                dwell_d = dwell_q + 32'h0000_0001;
            end
        end else begin
            dwell_d = 32'h0000_0000;
        end
        if (cls == CL_NICAM) begin
            if (!nicam_locked_i || (nicam_err_rate_i > NIC_ERR_HI)) begin
                fallback_d = 1'b1;
            end else if (nicam_err_rate_i < NIC_ERR_LO) begin
                fallback_d = 1'b0;
            end
        end else begin
            fallback_d = 1'b0;
        end
        if (reg_write_i) begin
            unique case (reg_addr_i)
                A_STD: begin
                    std_sel_d = reg_wdata_i[7:0];
                    active_d = reg_wdata_i[7:0];
                    dwell_d = 32'h0000_0000;
                end
                A_CTRL: ctrl_d = reg_wdata_i;
                A_PRE_ANA: pre_ana_d = reg_wdata_i;
                A_PRE_DIG: pre_dig_d = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_read_i) begin
            unique case (reg_addr_i)
                A_STD: rdata_d = {8'h00, std_sel_q};
                A_CTRL: rdata_d = ctrl_q;
                A_PRE_ANA: rdata_d = pre_ana_q;
                A_PRE_DIG: rdata_d = pre_dig_q;
                A_STATUS: rdata_d = {fallback_q, secondary_audio_program_i, pilot_i,
                                     fm_id_bilingual_i, fm_id_stereo_i, mode_q,
                                     active_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            std_sel_q <= STD_RST;
            active_q <= STD_RST;
            ctrl_q <= CTRL_RST;
            pre_ana_q <= PRE_RST;
            pre_dig_q <= PRE_RST;
            dwell_q <= 32'h0000_0000;
            fallback_q <= 1'b0;
            rdata_q <= 16'h0000;
            de_ana_q <= DE_50US;
            de_dig_q <= DE_OFF;
        end else begin
            std_sel_q <= std_sel_d;
            active_q <= active_d;
            ctrl_q <= ctrl_d;
            pre_ana_q <= pre_ana_d;
            pre_dig_q <= pre_dig_d;
            dwell_q <= dwell_d;
            fallback_q <= fallback_d;
            rdata_q <= rdata_d;
            de_ana_q <= de_ana_d;
            de_dig_q <= de_dig_d;
        end
    end

    // Audio state
    logic valid_q, valid_d;
    logic signed [15:0] c0l_q, c0r_q, c1l_q, c1r_q, c3l_q, c3r_q, c4l_q, c4r_q;
    logic signed [15:0] c0l_d, c0r_d, c1l_d, c1r_d, c3l_d, c3r_d, c4l_d, c4r_d;
    logic signed [15:0] st_l, st_r;
    asss_mode_e target;

    // Primary carries mono or sum, secondary the difference
    assign st_l = sat16($signed({primary_i[15], primary_i}) +
                        $signed({secondary_i[15], secondary_i}));
    assign st_r = sat16($signed({primary_i[15], primary_i}) -
                        $signed({secondary_i[15], secondary_i}));

    always_comb begin
        target = MD_MONO;
        unique case (cls)
            CL_FMID: begin
                if (fm_id_bilingual_i) begin
                    target = MD_BILING;
                end else if (fm_id_stereo_i) begin
                    target = MD_STEREO;
                end
            end
            CL_NICAM: begin
                if (!fallback_q) begin
                    unique case (digital_sound_control_bits_i)
                        DCB_STEREO: target = MD_NIC_STEREO;
                        DCB_BILING: target = MD_NIC_BILING;
                        DCB_MONO: target = MD_NIC_MONO;
                        default: target = MD_MONO;
                    endcase
                end
            end
            CL_PILOT: target = pilot_i ? MD_STEREO : MD_MONO;
            CL_SAP: begin
                if (secondary_audio_program_i) begin
                    target = MD_BILING;
                end else if (pilot_i) begin
                    target = MD_STEREO;
                end
            end
            default: target = MD_MONO;
        endcase
    end

    always_comb begin
        mode_d = mode_q;
        valid_d = sample_strobe_i;
        c0l_d = c0l_q;
        c0r_d = c0r_q;
        c1l_d = c1l_q;
        c1r_d = c1r_q;
        c3l_d = c3l_q;
        c3r_d = c3r_q;
        c4l_d = c4l_q;
        c4r_d = c4r_q;
        if (sample_strobe_i) begin
            if (auto_en) begin
                mode_d = target;
            end else begin
                unique case (ctrl_q[CTRL_MAT_LSB+:2])
                    2'h0: mode_d = MD_MONO;
                    2'h1: mode_d = MD_STEREO;
                    default: mode_d = MD_BILING;
                endcase
            end
            c0l_d = primary_i;
            c0r_d = primary_i;
            c1l_d = primary_i;
            c1r_d = primary_i;
            c3l_d = primary_i;
            c3r_d = primary_i;
            c4l_d = primary_i;
            c4r_d = primary_i;
            unique case (mode_d)
                MD_MONO: ;
                MD_STEREO: begin
                    c0l_d = st_l;
                    c0r_d = st_r;
                    c1l_d = st_l;
                    c1r_d = st_r;
                    c3l_d = st_l;
                    c3r_d = st_r;
                    c4l_d = st_l;
                    c4r_d = st_r;
                end
                MD_BILING: begin
                    c0r_d = secondary_i;
                    c1r_d = secondary_i;
                    c4l_d = secondary_i;
                    c4r_d = secondary_i;
                end
                MD_NIC_MONO: begin
                    c1l_d = nicam_left_i;
                    c1r_d = nicam_left_i;
                    c3l_d = nicam_left_i;
                    c3r_d = nicam_left_i;
                    c4l_d = nicam_left_i;
                    c4r_d = nicam_left_i;
                end
                MD_NIC_STEREO: begin
                    c1l_d = nicam_left_i;
                    c1r_d = nicam_right_i;
                    c3l_d = nicam_left_i;
                    c3r_d = nicam_right_i;
                    c4l_d = nicam_left_i;
                    c4r_d = nicam_right_i;
                end
                MD_NIC_BILING: begin
                    c1l_d = nicam_left_i;
                    c1r_d = nicam_right_i;
                    c3l_d = nicam_left_i;
                    c3r_d = nicam_left_i;
                    c4l_d = nicam_right_i;
                    c4r_d = nicam_right_i;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_q <= MD_MONO;
            valid_q <= 1'b0;
            c0l_q <= 16'sh0000;
            c0r_q <= 16'sh0000;
            c1l_q <= 16'sh0000;
            c1r_q <= 16'sh0000;
            c3l_q <= 16'sh0000;
            c3r_q <= 16'sh0000;
            c4l_q <= 16'sh0000;
            c4r_q <= 16'sh0000;
        end else begin
            mode_q <= mode_d;
            valid_q <= valid_d;
            c0l_q <= c0l_d;
            c0r_q <= c0r_d;
            c1l_q <= c1l_d;
            c1r_q <= c1r_d;
            c3l_q <= c3l_d;
            c3r_q <= c3r_d;
            c4l_q <= c4l_d;
            c4r_q <= c4r_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign demod_std_o = active_q;
    assign deemph_analog_o = de_ana_q;
    assign deemph_digital_o = de_dig_q;
    assign prescale_analog_o = pre_ana_q;
    assign prescale_digital_o = pre_dig_q;
    assign dematrix_mode_o = mode_q;
    assign sample_valid_o = valid_q;
    assign ch0_left_o = c0l_q;
    assign ch0_right_o = c0r_q;
    assign ch1_left_o = c1l_q;
    assign ch1_right_o = c1r_q;
    assign ch3_left_o = c3l_q;
    assign ch3_right_o = c3r_q;
    assign ch4_left_o = c4l_q;
    assign ch4_right_o = c4r_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    deemph_map_a: assert property (##1 de_ana_q == deemph_ana($past(active_q)))
        else $error("analog deemphasis does not follow standard");
    std_write_a: assert property (std_wr |=> active_q == $past(reg_wdata_i[7:0]))
        else $error("written standard not applied");
    id_hold_a: assert property (auto_en && id_found && !std_wr |=> $stable(active_q))
        else $error("standard changed while identified");
    alt_bg_a: assert property (auto_en && !id_found && !std_wr && dwell_q >= DWELL_LAST
        && (active_q == S_BG_FM) |=> active_q == S_BG_NIC)
        else $error("B/G alternation missed");
    alt_dk_a: assert property (auto_en && !id_found && !std_wr && dwell_q >= DWELL_LAST
        && (active_q == S_DK3_FM) |=> active_q == S_DK_NIC)
        else $error("D/K alternation missed");
    fallback_a: assert property (cls == CL_NICAM && !nicam_locked_i |=> fallback_q)
        else $error("no fallback on NICAM loss");
    boundary_a: assert property (!sample_strobe_i |=> $stable(mode_q) && $stable(c1l_q))
        else $error("channel changed between samples");
    nic_ch0_a: assert property (sample_strobe_i && auto_en && cls == CL_NICAM
        |=> c0l_q == $past(primary_i) && c0r_q == c0l_q)
        else $error("channel 0 not analog mono under NICAM");
    biling_a: assert property (valid_q && mode_q == MD_BILING
        |-> c3l_q == c3r_q && c4l_q == c4r_q && c1l_q == c3l_q && c1r_q == c4r_q)
        else $error("bilingual channel layout wrong");
    sap_a: assert property (sample_strobe_i && auto_en && cls == CL_SAP
        && secondary_audio_program_i |=> mode_q == MD_BILING)
        else $error("SECONDARY_AUDIO_PROGRAM not selected");
    pilot_a: assert property (sample_strobe_i && auto_en && cls == CL_PILOT
        && pilot_i |=> mode_q == MD_STEREO)
        else $error("pilot stereo not selected");

    alt_step_c: cover property (auto_en && dwell_q >= DWELL_LAST && !id_found ##1 1);
    fallback_c: cover property (fallback_q ##[1:1000] !fallback_q);
    nic_biling_c: cover property (valid_q && mode_q == MD_NIC_BILING);
endmodule : asss_top

// >>> verif/asss_demod_model.sv
// Purpose: Demodulator stand-in that hands audio samples to the block
// Assumes: fire_i asks for one sample, presented at the next edge
// Notes: Outside a sample the data lines carry the inverted values
module asss_demod_model #(
    parameter logic [15:0] P = 16'h1000,
    parameter logic [15:0] S = 16'h0400,
    parameter logic [15:0] NL = 16'h2000,
    parameter logic [15:0] NR = 16'h3000
) (
    // Clock and request
    input wire logic clk_i,
    input wire logic fire_i,
    // Audio towards the block
    output logic strobe_o,
    output logic signed [15:0] primary_o,
    output logic signed [15:0] secondary_o,
    output logic signed [15:0] nicam_left_o,
    output logic signed [15:0] nicam_right_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Data is only good in the strobe cycle, so the block must take it there
    always @(posedge clk_i) begin
        strobe_o <= fire_i;
        primary_o <= fire_i ? P : ~P;
        secondary_o <= fire_i ? S : ~S;
        nicam_left_o <= fire_i ? NL : ~NL;
        nicam_right_o <= fire_i ? NR : ~NR;
    end
endmodule : asss_demod_model

// >>> verif/asss_test.sv
// Purpose: Self-checking bench for the automatic sound select block
// Assumes: Short dwell parameter so that alternation shows quickly
// Notes: Table rows cover the per-standard modes; special cases follow
module asss_test;
    import asss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DW = 16;
    localparam logic [15:0] P = 16'h1000;
    localparam logic [15:0] S = 16'h0400;
    localparam logic [15:0] NL = 16'h2000;
    localparam logic [15:0] NR = 16'h3000;
    typedef struct packed {
        logic [7:0] std; logic [15:0] ctl; logic [1:0] id; logic [1:0] dcb;
        logic lock; logic pil; logic prog; logic [2:0] mode;
    } asss_row_s;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic we = 1'b0, re = 1'b0, fire = 1'b0, id_st = 1'b0, id_bi = 1'b0;
    logic lock = 1'b0, pil = 1'b0, prog = 1'b0, strobe, valid;
    logic [1:0] dcb = 2'h0;
    logic [7:0] err = 8'h00;
    logic [7:0] std_o;
    logic [1:0] de_a, de_d;
    logic [2:0] mode_o;
    logic [15:0] rdata, pre_a, pre_d;
    logic signed [15:0] p, s, nl, nr;
    logic signed [15:0] ch [8];
    int fails = 0;
    int samples_checked = 0;
    asss_row_s rows [15] = '{
        '{8'h02, 16'h1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, MD_MONO},
        '{8'h02, 16'h1, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0, MD_STEREO},
        '{8'h30, 16'h1, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, MD_BILING},
        '{8'h08, 16'h1, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, MD_NIC_STEREO},
        '{8'h09, 16'h1, 2'h0, 2'h1, 1'b1, 1'b0, 1'b0, MD_NIC_BILING},
        '{8'h0A, 16'h1, 2'h0, 2'h2, 1'b1, 1'b0, 1'b0, MD_NIC_MONO},
        '{8'h0A, 16'h1, 2'h0, 2'h3, 1'b1, 1'b0, 1'b0, MD_MONO},
        '{8'h0C, 16'h1, 2'h0, 2'h2, 1'b0, 1'b0, 1'b0, MD_MONO},
        '{8'h0C, 16'h1, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, MD_NIC_STEREO},
        '{8'h20, 16'h1, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0, MD_STEREO},
        '{8'h40, 16'h1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, MD_MONO},
        '{8'h21, 16'h1, 2'h0, 2'h0, 1'b0, 1'b1, 1'b1, MD_BILING},
        '{8'h21, 16'h1, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0, MD_STEREO},
        '{8'h02, 16'h10, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, MD_STEREO},
        '{8'h30, 16'h0, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, MD_MONO}};
    logic [7:0] errs [5] = '{8'hC0, 8'hC1, 8'h80, 8'h40, 8'h3F};
    logic [2:0] hyst [5] = '{MD_NIC_STEREO, MD_MONO, MD_MONO, MD_MONO, MD_NIC_STEREO};
    logic [7:0] dk [4] = '{S_DK2_FM, S_DK3_FM, S_DK_NIC, S_DK1_FM};

    always #4 clk_i = ~clk_i;

    asss_demod_model #(.P(P), .S(S), .NL(NL), .NR(NR)) partner (.clk_i(clk_i), .fire_i(fire),
        .strobe_o(strobe), .primary_o(p), .secondary_o(s), .nicam_left_o(nl),
        .nicam_right_o(nr));

    asss_top #(.DWELL(DW)) dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata),
        .fm_id_stereo_i(id_st), .fm_id_bilingual_i(id_bi), .digital_sound_control_bits_i(dcb),
        .nicam_locked_i(lock), .nicam_err_rate_i(err), .pilot_i(pil),
        .secondary_audio_program_i(prog), .sample_strobe_i(strobe), .primary_i(p),
        .secondary_i(s), .nicam_left_i(nl), .nicam_right_i(nr), .demod_std_o(std_o),
        .deemph_analog_o(de_a), .deemph_digital_o(de_d), .prescale_analog_o(pre_a),
        .prescale_digital_o(pre_d), .dematrix_mode_o(mode_o), .sample_valid_o(valid),
        .ch0_left_o(ch[0]), .ch0_right_o(ch[1]), .ch1_left_o(ch[2]), .ch1_right_o(ch[3]),
        .ch3_left_o(ch[4]), .ch3_right_o(ch[5]), .ch4_left_o(ch[6]), .ch4_right_o(ch[7]));

    task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic apply(input asss_row_s r);
        wr(A_STD, {8'h00, r.std});
        wr(A_CTRL, r.ctl);
        {id_bi, id_st} <= r.id;
        dcb <= r.dcb;
        lock <= r.lock;
        pil <= r.pil;
        prog <= r.prog;
    endtask : apply

    task automatic sample;
        int i;
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        for (i = 0; i < 8 && valid !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk("valid", valid, 1'b1);
    endtask : sample

    function automatic logic [127:0] chans(input logic [2:0] m);
        logic [15:0] l, r;
        l = P + S;
        r = P - S;
        case (m)
            MD_STEREO: return {l, r, l, r, l, r, l, r};
            MD_BILING: return {P, S, P, S, P, P, S, S};
            MD_NIC_MONO: return {P, P, NL, NL, NL, NL, NL, NL};
            MD_NIC_STEREO: return {P, P, NL, NR, NL, NR, NL, NR};
            MD_NIC_BILING: return {P, P, NL, NR, NL, NL, NR, NR};
            default: return {8{P}};
        endcase
    endfunction : chans

    task automatic check_out(input logic [2:0] m);
        chk("mode", mode_o, m);
        chk("channels", {ch[0], ch[1], ch[2], ch[3], ch[4], ch[5], ch[6], ch[7]}, chans(m));
    endtask : check_out

    task automatic wait_std(input logic [7:0] e);
        logic [7:0] old;
        int i;
        old = std_o;
        for (i = 0; i < 4 * DW && std_o === old; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk("standard", std_o, e);
    endtask : wait_std

    initial begin
        #(5000 * 8);
        fails++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        logic [15:0] d;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(A_CTRL, d);
        chk("ctrl reset", d, CTRL_RST);
        rd(A_STD, d);
        chk("std reset", d, {8'h00, STD_RST});
        rd(8'h14, d);
        chk("unmapped", d, 16'h0000);
        chk("deemph reset", de_d, DE_OFF);
        $display("reset test done");
        for (int k = 0; k < 15; k++) begin
            apply(rows[k]);
            sample();
            check_out(rows[k].mode);
            chk("deemph", de_d, (rows[k].std inside {[8'h08:8'h0D]}) ? DE_J17 : DE_OFF);
            chk("deemph analog", de_a, rows[k].std == 8'h09 ? DE_OFF :
                (rows[k].std inside {8'h02, 8'h20, 8'h21, 8'h30, 8'h40}) ? DE_75US : DE_50US);
        end
        $display("table test done");
        apply(rows[0]);
        sample();
        @(posedge clk_i);
        id_st <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        chk("mode held", mode_o, MD_MONO);
        sample();
        check_out(MD_STEREO);
        $display("boundary test done");
        apply('{8'h0A, 16'h1, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, MD_MONO});
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_i);
            err <= errs[k];
            sample();
            check_out(hyst[k]);
        end
        err <= 8'h00;
        $display("hysteresis test done");
        apply('{8'h03, 16'h1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, MD_MONO});
        wait_std(S_BG_NIC);
        wait_std(S_BG_FM);
        rd(A_STATUS, d);
        chk("status std", d[7:0], S_BG_FM);
        apply('{8'h04, 16'h1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, MD_MONO});
        for (int k = 0; k < 4; k++) begin
            wait_std(dk[k]);
        end
        apply('{8'h03, 16'h1, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0, MD_MONO});
        repeat (4 * DW) @(posedge clk_i);
        #1;
        chk("std held", std_o, S_BG_FM);
        $display("alternation test done");
        wr(A_PRE_ANA, 16'h1234);
        wr(A_PRE_DIG, 16'hABCD);
        rd(A_PRE_ANA, d);
        chk("prescale read", d, 16'h1234);
        chk("prescale analog", pre_a, 16'h1234);
        chk("prescale digital", pre_d, 16'hABCD);
        $display("prescale test done");
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(A_CTRL, d);
        chk("ctrl after reset", d, CTRL_RST);
        chk("std after reset", std_o, STD_RST);
        chk("prescale after reset", pre_a, PRE_RST);
        chk("mode after reset", mode_o, MD_MONO);
        $display("mid-run reset test done");
        test_done();
    end
endmodule : asss_test
